// ==== verilog/sequencer_pkg.sv ====
// constants and types shared by the four-channel sample sequencer
package sequencer_pkg;
   localparam int          DATA_W          = 12;
   localparam int          CHANNELS        = 4;
   localparam int          BITS            = 12;
   localparam logic [1:0]  LEAD_TICKS      = 2'h2;
   localparam logic [4:0]  PHASE_LAST      = 5'h12;
   localparam logic [6:0]  SEQ_TICKS       = 7'h4E;
   localparam logic [11:0] MSB_TRIAL       = 12'h800;
   localparam int          SYS_CLK_HZ      = 10_000_000;
   localparam int          INT_CLK_HZ      = 2_500_000;
   localparam logic [1:0]  CLK_DIV_LAST    = 2'((SYS_CLK_HZ / INT_CLK_HZ) - 1);
   localparam int          MAX_CONV_TIME_NS = 32500;
   localparam int          MAX_CONV_CYCLES = MAX_CONV_TIME_NS * (SYS_CLK_HZ / 1_000_000) / 1000;
   localparam int          CLK_IDLE_CYCLES = 16;
   localparam logic        DONE_N_RESET    = 1'h1;
   localparam logic        START_PIN_RESET = 1'h1;

   typedef enum logic {SAR_IDLE, SAR_RUN} sar_mode_t;

   typedef struct packed {
      sar_mode_t   mode;
      logic [1:0]  lead;
      logic [4:0]  phase;
      logic [1:0]  chan;
      logic [1:0]  store_chan;
      logic [11:0] code;
      logic [6:0]  tick_cnt;
      logic        store;
      logic        done;
      logic [11:0] result;
   } sar_state_t;

   typedef struct packed {
      logic             cs1, cs2, rd1, rd2;
      logic             st1, st2, st3;
      logic             ck1, ck2, ck3;
      logic             cmp1, cmp2;
      logic [1:0]       div;
      logic [7:0]       idle_cnt;
      logic             hold;
      logic [1:0]       ptr;
      logic             done_n;
      logic             rd_act;
      logic [11:0]      data;
      logic [3:0][11:0] results;
   } seq_state_t;
endpackage

// ==== verilog/sar_engine.sv ====
// successive approximation engine that walks the four held channels
`timescale 1ns/10ps
`default_nettype none
module sar_engine (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        tick_i,
   input  wire logic        start_i,
   input  wire logic        comp_i,
   output logic             busy_o,
   output logic [1:0]       chan_o,
   output logic [11:0]      dac_o,
   output logic             store_o,
   output logic [1:0]       store_chan_o,
   output logic [11:0]      result_o,
   output logic             done_o
);
   sequencer_pkg::sar_state_t s;
   sequencer_pkg::sar_state_t next_s;
   logic [3:0] bit_idx;

   // one conversion tick: lead-in, then 19 phases per channel
   always_comb begin
      next_s = s;
      bit_idx = 4'(sequencer_pkg::BITS - int'(s.phase));
      next_s.store = 1'b0;
      next_s.done = 1'b0;
      unique case (s.mode)
         sequencer_pkg::SAR_IDLE: begin
            if (start_i) begin
               next_s.mode = sequencer_pkg::SAR_RUN;
               next_s.lead = '0;
               next_s.phase = '0;
               next_s.chan = '0;
               next_s.tick_cnt = '0;
            end
         end
         sequencer_pkg::SAR_RUN: begin
            if (tick_i) begin
               // two lead ticks plus 19 a channel, 78 in all
               next_s.tick_cnt = s.tick_cnt + 7'h1;
               if (s.lead != sequencer_pkg::LEAD_TICKS) begin
                  next_s.lead = s.lead + 2'h1;   // internal reset time before channel 1
               end else begin
                  if (s.phase == 5'h0) begin
                     next_s.code = sequencer_pkg::MSB_TRIAL;
                  end else if (int'(s.phase) <= sequencer_pkg::BITS) begin
                     // keep the trial bit only when the input sits above the dac
                     if (!comp_i) begin
                        next_s.code[bit_idx] = 1'b0;
                     end
                     if (bit_idx != 4'h0) begin
                        next_s.code[bit_idx - 4'h1] = 1'b1;
                     end
                  end
                  if (s.phase == sequencer_pkg::PHASE_LAST) begin
                     next_s.store = 1'b1;
                     next_s.store_chan = s.chan;
                     // two's complement: offset binary with msb inverted
                     next_s.result = {~s.code[11], s.code[10:0]};
                     next_s.phase = '0;
                     if (s.chan == 2'(sequencer_pkg::CHANNELS - 1)) begin
                        next_s.mode = sequencer_pkg::SAR_IDLE;
                        next_s.done = 1'b1;
                     end else begin
                        next_s.chan = s.chan + 2'h1;
                     end
                  end else begin
                     next_s.phase = s.phase + 5'h1;
                  end
               end
            end
         end
      endcase
   end

   // state register
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign busy_o       = (s.mode == sequencer_pkg::SAR_RUN);
   assign chan_o       = s.chan;
   assign dac_o        = s.code;
   assign store_o      = s.store;
   assign store_chan_o = s.store_chan;
   assign result_o     = s.result;
   assign done_o       = s.done;

   // each store but the last is followed by the next channel
   AST_CHAN_STEP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      store_o && !done_o |-> chan_o == store_chan_o + 2'h1)
      else $error("channel did not advance after store");

   AST_SEQ_TICKS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      done_o |-> s.tick_cnt == sequencer_pkg::SEQ_TICKS)
      else $error("sequence tick count wrong");

   // sign bit is inverted offset msb
   AST_TWOS_SIGN: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      store_o |-> result_o[11] == !$past(s.code[11]) && result_o[10:0] == $past(s.code[10:0]))
      else $error("result not two's complement");
endmodule // sar_engine
`default_nettype wire

// ==== verilog/four_channel_sample_sequencer.sv ====
// control logic of the four-channel simultaneous-sampling converter
`timescale 1ns/10ps
`default_nettype none
module four_channel_sample_sequencer #(
   parameter int CLK_IDLE_CYCLES = sequencer_pkg::CLK_IDLE_CYCLES
) (
   input  wire logic        SYS_CLK_I,
   input  wire logic        RST_N_I,
   input  wire logic        CONVERT_START_N_I,
   input  wire logic        CS_N_I,
   input  wire logic        RD_N_I,
   input  wire logic        EXT_CLK_I,
   input  wire logic        COMPARATOR_I,
   output logic             HOLD_O,
   output logic [1:0]       CHANNEL_SEL_O,
   output logic [11:0]      DAC_CODE_O,
   output logic             DONE_N_O,
   output logic [11:0]      RESULT_BUS_O,
   output logic             RESULT_BUS_OE_N_O
);
   localparam int MAX_WAIT = sequencer_pkg::MAX_CONV_CYCLES;
   localparam logic [7:0] IDLE_LIMIT = 8'(CLK_IDLE_CYCLES);

   sequencer_pkg::seq_state_t s;
   sequencer_pkg::seq_state_t next_s;

   logic        start_edge;
   logic        ext_edge;
   logic        int_mode;
   logic        tick;
   logic        sel;
   logic        read_start;
   logic        read_end;
   logic        busy;
   logic        store;
   logic [1:0]  store_chan;
   logic [11:0] result;
   logic        seq_done;
   logic [11:0] cur_word;

   // edges are taken from the second and third stages only
   assign start_edge = s.st2 && !s.st3;
   assign ext_edge   = s.ck2 && !s.ck3;
   // a clock pin with no edges for a while means internal oscillator
   assign int_mode   = (s.idle_cnt == IDLE_LIMIT);
   // one tick per source edge, four cycles apart at 2.5 MHz
   assign tick       = int_mode ? (s.div == sequencer_pkg::CLK_DIV_LAST) : ext_edge;
   assign sel        = s.cs2 && s.rd2;
   assign read_start = sel && !s.rd_act;
   assign read_end   = !sel && s.rd_act;
   // the only read path from a result register is the read pointer
   assign cur_word   = s.results[s.ptr];

   sar_engine u_sar (
      .clk_i        (SYS_CLK_I),
      .rst_n_i      (RST_N_I),
      .tick_i       (tick),
      .start_i      (start_edge && !busy),
      .comp_i       (s.cmp2),
      .busy_o       (busy),
      .chan_o       (CHANNEL_SEL_O),
      .dac_o        (DAC_CODE_O),
      .store_o      (store),
      .store_chan_o (store_chan),
      .result_o     (result),
      .done_o       (seq_done)
   );

   // next state of synchronisers, clock source, hold, pointer and read path
   always_comb begin
      next_s = s;
      next_s.cs1 = !CS_N_I;
      next_s.cs2 = s.cs1;
      next_s.rd1 = !RD_N_I;
      next_s.rd2 = s.rd1;
      next_s.st1 = CONVERT_START_N_I;
      next_s.st2 = s.st1;
      next_s.st3 = s.st2;
      next_s.ck1 = EXT_CLK_I;
      next_s.ck2 = s.ck1;
      next_s.ck3 = s.ck2;
      next_s.cmp1 = COMPARATOR_I;
      next_s.cmp2 = s.cmp1;
      // internal oscillator is a divider enable, never a second clock
      next_s.div = (s.div == sequencer_pkg::CLK_DIV_LAST) ? 2'h0 : s.div + 2'h1;
      if (ext_edge) begin
         next_s.idle_cnt = '0;
      end else if (!int_mode) begin
         next_s.idle_cnt = s.idle_cnt + 8'h1;
      end
      // a start while busy is not taken; the running sequence goes on
      // all track/holds go to hold on the start edge
      if (start_edge && !busy) begin
         next_s.hold = 1'b1;
      end else if (seq_done) begin
         next_s.hold = 1'b0;
      end
      // result lands in its channel's register
      if (store) begin
         next_s.results[store_chan] = result;
      end
      // start edge rewinds the pointer, even mid-sequence
      if (start_edge) begin
         next_s.ptr = '0;
      end else if (read_end) begin
         // each finished read moves to the next word
         next_s.ptr = s.ptr + 2'h1;
      end
      // word under the pointer is latched as the read begins
      next_s.rd_act = sel;
      if (read_start) begin
         next_s.data = cur_word;
      end
      // done goes low with the fourth store; set wins over release
      if (seq_done) begin
         next_s.done_n = 1'b0;
      end else if (read_start && s.ptr == 2'h0) begin
         // first read releases the done flag
         next_s.done_n = 1'b1;
      end
   end

   // state register; start pin sync resets high so release is no edge
   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         s <= '0;
         s.st1 <= sequencer_pkg::START_PIN_RESET;
         s.st2 <= sequencer_pkg::START_PIN_RESET;
         s.st3 <= sequencer_pkg::START_PIN_RESET;
         s.done_n <= sequencer_pkg::DONE_N_RESET;
      end else begin
         s <= next_s;
      end
   end

   assign HOLD_O            = s.hold;
   assign DONE_N_O          = s.done_n;
   assign RESULT_BUS_O      = s.data;
   // bus enabled only while select and read are both held
   assign RESULT_BUS_OE_N_O = !s.rd_act;

   sequence seq_start;
      start_edge && !busy;
   endsequence

   sequence seq_read_begin;
      sel && !s.rd_act;
   endsequence

   // helper: cycles since the accepted start edge
   logic [9:0] wait_cnt;
   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I || (start_edge && !busy)) begin
         wait_cnt <= '0;
      end else if (busy && wait_cnt != 10'h3FF) begin
         wait_cnt <= wait_cnt + 10'h1;
      end
   end

   AST_HOLD_ON_START: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      seq_start |=> HOLD_O && CHANNEL_SEL_O == 2'h0)
      else $error("start edge did not hold channel 1");

   AST_STORE_REG: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      store |=> s.results[$past(store_chan)] == $past(result))
      else $error("result not stored in its register");

   AST_DONE_AFTER_FOURTH: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      $fell(DONE_N_O) |-> $past(store) && $past(store_chan) == 2'h3)
      else $error("done flag without fourth store");

   AST_DONE_TIME: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      seq_done |-> wait_cnt <= 10'(MAX_WAIT))
      else $error("conversion took too long");

   AST_READ_WORD: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      seq_read_begin |=> RESULT_BUS_O == $past(cur_word) && !RESULT_BUS_OE_N_O)
      else $error("read returned wrong word");

   AST_PTR_STEP: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      read_end && !start_edge |=> s.ptr == $past(s.ptr) + 2'h1)
      else $error("pointer did not step after read");

   AST_DONE_RELEASE: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      seq_read_begin ##0 (s.ptr == 2'h0 && !seq_done) |=> DONE_N_O)
      else $error("first read did not release done");

   AST_PTR_RESET: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      start_edge |=> s.ptr == 2'h0)
      else $error("start edge did not rewind pointer");

   AST_BUS_GATED: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      !RESULT_BUS_OE_N_O |-> $past(s.cs2) && $past(s.rd2))
      else $error("bus driven without select and read");

   // clock-source helper: a tick taken while the divider drives
   sequence seq_int_tick;
      int_mode && tick;
   endsequence

   // divider ticks stay four cycles apart for the comparator
   AST_INT_TICK_GAP: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      seq_int_tick |=> (!tick) [*3])
      else $error("internal ticks too close together");

   // hold stands until the fourth result is stored
   AST_HOLD_STANDS: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      HOLD_O && !seq_done |=> HOLD_O)
      else $error("hold dropped before the fourth store");

   // done stands low until a first read begins
   AST_DONE_STANDS: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      !DONE_N_O && !(read_start && s.ptr == 2'h0) |=> !DONE_N_O)
      else $error("done flag released without a first read");

   // word on the bus stands for the whole strobe
   AST_BUS_STABLE: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      !RESULT_BUS_OE_N_O && sel |=> $stable(RESULT_BUS_O))
      else $error("bus word changed during a read");

   // result registers change only on a store
   AST_RESULTS_KEPT: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      !store |=> $stable(s.results))
      else $error("result register changed without a store");

   // bus is released the cycle after select or read goes away
   AST_BUS_RELEASE: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
      !sel |=> RESULT_BUS_OE_N_O)
      else $error("bus still driven after the strobe ended");
endmodule // four_channel_sample_sequencer
`default_nettype wire

// ==== testbench/host_model.sv ====
// host model: convert-start pulses and implicit-address reads of the result bus
`timescale 1ns/10ps
`default_nettype none
module host_model (
   input  wire logic        clk_i,
   input  wire logic        oe_n_i,
   input  wire logic [11:0] bus_i,
   output logic             start_n_o,
   output logic             cs_n_o,
   output logic             rd_n_o
);
   // all strobes idle high from time zero
   initial begin
      start_n_o = 1'h1;
      cs_n_o    = 1'h1;
      rd_n_o    = 1'h1;
   end

   task automatic start_conv();
      @(posedge clk_i) #1 start_n_o = 1'h0;
      repeat (3) @(posedge clk_i);
      #1 start_n_o = 1'h1;
   endtask

   task automatic read_word(output logic [11:0] w, output bit ok);
      int n;
      ok = 1'b0;
      w  = 12'h000;
      @(posedge clk_i) #1;
      cs_n_o = 1'h0;
      rd_n_o = 1'h0;
      // strobe held until the bus is seen enabled; word taken at that edge
      for (n = 0; n < 10 && !ok; n++) begin
         @(posedge clk_i);
         if (oe_n_i === 1'h0) begin
            ok = 1'b1;
            w  = bus_i;
         end
      end
      #1;
      rd_n_o = 1'h1;
      cs_n_o = 1'h1;
      // gap well above the three-cycle minimum so the bus is released again
      repeat (6) @(posedge clk_i);
   endtask
endmodule // host_model
`default_nettype wire

// ==== testbench/four_channel_sample_sequencer_tb.sv ====
// self-checking bench for the four-channel sample sequencer
`timescale 1ns/10ps
`default_nettype none
module four_channel_sample_sequencer_tb;
   logic        clk, rst_n, ext_clk, ext_en, comp;
   logic        start_n, cs_n, rd_n;
   logic        hold, done_n, oe_n;
   logic [1:0]  chan, last_ch;
   logic [11:0] dac, bus;
   logic [11:0] held [4];
   logic [31:0] seed;
   int          err_total, num_checks, r;

   // idle window shortened, still longer than the external clock period
   four_channel_sample_sequencer #(.CLK_IDLE_CYCLES(8)) dut (
      .SYS_CLK_I(clk), .RST_N_I(rst_n), .CONVERT_START_N_I(start_n), .CS_N_I(cs_n), .RD_N_I(rd_n),
      .EXT_CLK_I(ext_clk), .COMPARATOR_I(comp), .HOLD_O(hold), .CHANNEL_SEL_O(chan),
      .DAC_CODE_O(dac), .DONE_N_O(done_n), .RESULT_BUS_O(bus), .RESULT_BUS_OE_N_O(oe_n));

   host_model host (.clk_i(clk), .oe_n_i(oe_n), .bus_i(bus), .start_n_o(start_n), .cs_n_o(cs_n),
      .rd_n_o(rd_n));

   // 10 MHz system clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // 2.5 MHz external clock, held low (internal oscillator) unless enabled
   initial begin
      ext_clk = 1'b0;
      forever #200 ext_clk = ext_en ? ~ext_clk : 1'b0;
   end

   // comparator of held input half an lsb above its code
   always @(posedge clk) #1 comp = (held[chan] >= dac);

   // channel select steps up by one
   always @(posedge clk) begin
      if (hold === 1'h1 && chan !== last_ch)
         check("channel step", {30'h0, chan}, {30'h0, last_ch + 2'h1});
      last_ch <= chan;
   end

   function automatic logic [31:0] next_rand(input logic [31:0] x);
      return (x >> 1) ^ (x[0] ? 32'hA3000000 : 32'h00000000);
   endfunction

   // offset-binary held value read back as two's complement
   function automatic logic [11:0] to_twos(input logic [11:0] v);
      return {~v[11], v[10:0]};
   endfunction

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // one full sequence: hold moment, done timing, bus quiet meanwhile
   task automatic convert();
      int n, hold_at;
      bit bus_on;
      hold_at = 0;
      bus_on  = 1'b0;
      host.start_conv();
      for (n = 1; n < 400 && done_n !== 1'h0; n++) begin
         @(posedge clk) #1;
         if (hold === 1'h1 && hold_at == 0)
            hold_at = n;
         if (oe_n !== 1'h1)
            bus_on = 1'b1;
      end
      check("hold edge", hold_at, 3);
      check("bus idle", bus_on, 0);
      check("done window", n >= 312 && n <= 325, 1);
      check("hold at done", hold, 0);
      if (done_n !== 1'h0) begin
         check("done flag", done_n, 0);
         test_done();
      end
   endtask

   task automatic read_all(input int cnt);
      logic [11:0] w;
      bit ok;
      int i;
      for (i = 0; i < cnt; i++) begin
         host.read_word(w, ok);
         if (!ok) begin
            check("read answer", ok, 1);
            test_done();
         end
         check("result word", w, to_twos(held[i]));
         check("done after read", done_n, 1);
         check("bus released", oe_n, 1);
      end
   endtask

   initial begin
      rst_n      = 1'h0;
      ext_en     = 1'b0;
      comp       = 1'h0;
      seed       = 32'hF783A328;
      err_total  = 0;
      num_checks = 0;
      held       = '{12'h000, 12'h000, 12'h000, 12'h000};
      repeat (10) @(posedge clk);
      #1 rst_n = 1'h1;
      @(posedge clk) #1;
      check("reset hold", hold, 0);
      check("reset done", done_n, 1);
      check("reset bus", oe_n, 1);
      $display("test reset done");
      held = '{12'h7FF, 12'h800, 12'hFFF, 12'hFFE};
      convert();
      read_all(4);
      held = '{12'h000, 12'h001, 12'h801, 12'h555};
      convert();
      read_all(4);
      $display("test corner codes done");
      for (r = 0; r < 4; r++) begin
         foreach (held[i]) begin
            seed    = next_rand(seed);
            held[i] = seed[11:0];
         end
         convert();
         read_all(4);
      end
      $display("test random codes done");
      convert();
      read_all(2);
      convert();
      read_all(4);
      $display("test pointer rewind done");
      ext_en = 1'b1;
      convert();
      read_all(4);
      ext_en = 1'b0;
      $display("test external clock done");
      test_done();
   end
endmodule // four_channel_sample_sequencer_tb
`default_nettype wire
